// ### logic/dacpc_link.sv
// Serial-clock side: falling-edge counter, result shifting, event toggles.
// Assumes select high clears the frame state; words stay frozen during a frame.
`timescale 1ns/1ps
`include "dacpc_map.svh"
module dacpc_link
   import dacpc_pkg::*;
(
   input  wire logic  serial_clk,
   input  wire logic  rstn,
   dacpc_xing_if.link x
);

   logic [5:0] fall_cnt_reg;
   logic [5:0] fall_cnt_next;
   logic       dout_first_reg;
   logic       dout_second_reg;
   logic       done_reg;
   logic       trk_done_reg;
   logic       tog_two_reg;
   logic       tog_ten_reg;
   logic       tog_track_reg;
   logic       word_sel;
   logic [3:0] slot;

   // Data slot 2..13 carries msb..lsb, all other slots are zero
   function automatic logic dacpc_slot_bit(input logic [11:0] w, input logic [3:0] s);
      logic [4:0] idx;
      idx = `DACPC_SLOT_BASE - {1'b0, s};
      if (s >= `DACPC_SLOT_MSB && s <= `DACPC_SLOT_LSB)                  // see [RQ15] see [RQ11]
         return w[idx[3:0]];
      return 1'b0;
   endfunction : dacpc_slot_bit

   assign fall_cnt_next = (fall_cnt_reg == `DACPC_CNT_END) ? fall_cnt_reg : fall_cnt_reg + 6'h01;
   assign word_sel      = fall_cnt_next[4];
   assign slot          = fall_cnt_next[3:0];

   // Select high holds the frame in reset, so a falling edge coincident
   // with the select fall is never counted; rising edges are never counted
   always_ff @(negedge serial_clk or posedge x.cs_n) begin                 // see [RQ17] see [RQ18]
      if (x.cs_n) begin                                                     // see [RQ12]
         fall_cnt_reg    <= 6'h00;
         dout_first_reg  <= 1'b0;
         dout_second_reg <= 1'b0;
         done_reg        <= 1'b0;
      end else begin
         fall_cnt_reg    <= fall_cnt_next;                                  // see [RQ19]
         dout_first_reg  <= dacpc_slot_bit(word_sel ? x.word_second : x.word_first, slot);  // see [RQ13]
         dout_second_reg <= dacpc_slot_bit(word_sel ? x.word_first : x.word_second, slot);  // see [RQ24]
         done_reg        <= done_reg | (fall_cnt_next == `DACPC_CNT_END);  // see [RQ14]
      end
   end

   // Track-and-hold back to track on the rising edge after the 13th fall
   always_ff @(posedge serial_clk or posedge x.cs_n) begin
      if (x.cs_n)
         trk_done_reg <= 1'b0;
      else if (fall_cnt_reg >= `DACPC_CNT_TRACK)
         trk_done_reg <= 1'b1;
   end

   always_ff @(posedge serial_clk or negedge rstn) begin
      if (!rstn)
         tog_track_reg <= 1'b0;
      else if (fall_cnt_reg >= `DACPC_CNT_TRACK && !trk_done_reg)
         tog_track_reg <= ~tog_track_reg;                                   // see [RQ10]
   end

   // Toggles survive the frame reset so the core can still see them
   always_ff @(negedge serial_clk or negedge rstn) begin
      if (!rstn) begin
         tog_two_reg <= 1'b0;
         tog_ten_reg <= 1'b0;
      end else begin
         if (fall_cnt_next == `DACPC_CNT_TWO && fall_cnt_reg != `DACPC_CNT_TWO)
            tog_two_reg <= ~tog_two_reg;                                    // see [RQ1]
         if (fall_cnt_next == `DACPC_CNT_TEN && fall_cnt_reg != `DACPC_CNT_TEN)
            tog_ten_reg <= ~tog_ten_reg;                                    // see [RQ4]
      end
   end

   assign x.dout_first  = dout_first_reg;
   assign x.dout_second = dout_second_reg;
   assign x.done        = done_reg;
   assign x.tog_two     = tog_two_reg;
   assign x.tog_ten     = tog_ten_reg;
   assign x.tog_track   = tog_track_reg;

   AST_LEAD_ZERO: assert property (@(negedge serial_clk) disable iff (x.cs_n)  // see [RQ15]
      (fall_cnt_reg == 6'h00) |=> !dout_first_reg && !dout_second_reg)
      else $error("second leading zero missing");

   AST_MSB_SLOT: assert property (@(negedge serial_clk) disable iff (x.cs_n)   // see [RQ15]
      (fall_cnt_reg == 6'h01) |=> dout_first_reg == $past(x.word_first[11]))
      else $error("msb not on second falling edge");

   AST_TRAIL_ZERO: assert property (@(negedge serial_clk) disable iff (x.cs_n) // see [RQ11]
      (fall_cnt_reg == 6'h0d) |=> !dout_first_reg ##1 !dout_first_reg)
      else $error("trailing zeros missing");

   AST_CHAIN_WORD: assert property (@(negedge serial_clk) disable iff (x.cs_n) // see [RQ13]
      (fall_cnt_reg == 6'h11) |=> dout_first_reg == $past(x.word_second[11])
         && dout_second_reg == $past(x.word_first[11]))
      else $error("chained word not swapped in");

   // Checked on rising edges, since the host may stop right after the 32nd fall
   AST_END_DONE: assert property (@(posedge serial_clk) disable iff (x.cs_n)   // see [RQ14]
      done_reg == (fall_cnt_reg == `DACPC_CNT_END))
      else $error("line not released at 32nd edge");

endmodule : dacpc_link

// ### logic/dacpc_map.svh
// Constants of the dual converter serial read-out and power control block.
// Assumes inclusion by both design modules; definitions only.
`ifndef DACPC_MAP_SVH
`define DACPC_MAP_SVH

// Falling-edge counts inside one frame
`define DACPC_CNT_W          6
`define DACPC_CNT_TWO        6'h02
`define DACPC_CNT_TEN        6'h0a
`define DACPC_CNT_TRACK      6'h0d
`define DACPC_CNT_END        6'h20

// Bit slots inside one 16-slot word
`define DACPC_SLOT_MSB       4'h2
`define DACPC_SLOT_LSB       4'hd
`define DACPC_SLOT_BASE      5'h0d

// Result width
`define DACPC_RES_W          12

// Timing, in ns, and the ref_clk period
`define DACPC_REF_PERIOD_NS  25
`define DACPC_WAKE_FULL_NS   1500000
`define DACPC_WAKE_PART_NS   1000
`define DACPC_PART_DWELL_NS  67000

// Reset values
`define DACPC_SYNC_RST       4'h8

`endif

// ### logic/dacpc_pkg.sv
// Types shared by the dual converter control block.
// Assumes nothing of its surroundings.
package dacpc_pkg;

   typedef enum logic [1:0] {
      DACPC_NORMAL,
      DACPC_PARTIAL,
      DACPC_FULL
   } dacpc_pwr_t;

endpackage : dacpc_pkg

// ### logic/dacpc_top.sv
// Dual converter serial read-out and select-driven power mode control.
// Assumes select and serial clock come from a host, unrelated to ref_clk;
// converter words are synchronous to ref_clk and held by the analog core.
//
// Overview of operation
// [RQ1] Rise between edges 2 and 10: partial down
// [RQ2] Same abort in partial: full power-down
// [RQ3] Power-down takes effect without remaining clocks
// [RQ4] Select low past tenth edge powers up
// [RQ5] Host waits 1.5 ms after deep wake
// [RQ6] Partial wake 1 us after 67 us dwell
// [RQ7] Host runs one dummy cycle after supply
// [RQ8] Two or three dummy cycles reach power-downs
// [RQ9] Select fall: hold, sample, drive, convert
// [RQ10] Back to track after thirteenth falling edge
// [RQ11] Sixteen-clock frame gives two trailing zeros
// [RQ12] Select rise ends conversion, releases lines
// [RQ13] Longer frame shifts other converter's word
// [RQ14] Release at 32nd edge or select rise
// [RQ15] Two zeros, then twelve bits msb first
// [RQ16] Rising-edge host sees lsb at edge 13
// [RQ17] Falling edge coincident with select ignored
// [RQ18] Rising edge before first fall ignored
// [RQ19] Serial clock paces conversion and shifting
// [RQ20] Rise after tenth edge keeps power on
// [RQ21] Rise before second edge keeps power state
// [RQ22] Partial keeps reference and buffer powered
// [RQ23] Track normal, partial and full states
// [RQ24] Both converters sample and shift together
`timescale 1ns/1ps
`include "dacpc_map.svh"
module dacpc_top
   import dacpc_pkg::*;
#(
   parameter int WAKE_FULL_CYC  = (`DACPC_WAKE_FULL_NS + `DACPC_REF_PERIOD_NS - 1)
                                  / `DACPC_REF_PERIOD_NS,
   parameter int WAKE_PART_CYC  = (`DACPC_WAKE_PART_NS + `DACPC_REF_PERIOD_NS - 1)
                                  / `DACPC_REF_PERIOD_NS,
   parameter int PART_DWELL_CYC = (`DACPC_PART_DWELL_NS + `DACPC_REF_PERIOD_NS - 1)
                                  / `DACPC_REF_PERIOD_NS
)
(
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   input  wire logic        serial_clk,
   input  wire logic        select_n,
   input  wire logic [11:0] conv_first,
   input  wire logic [11:0] conv_second,
   output logic             result_line_first,
   output logic             result_line_first_oe,
   output logic             result_line_second,
   output logic             result_line_second_oe,
   output logic             track_mode,
   output logic             analog_on,
   output logic             reference_on,
   output logic [1:0]       power_mode,
   output logic             conversion_ready
);

   localparam int CNT_W = $clog2(WAKE_FULL_CYC + 1);
   localparam int DWL_W = $clog2(PART_DWELL_CYC + 1);

   generate
      if (WAKE_FULL_CYC < 1 || WAKE_PART_CYC < 1 || PART_DWELL_CYC < 1
          || WAKE_PART_CYC > WAKE_FULL_CYC) begin : g_bad_param
         $error("dacpc_top: wake counts must be positive, partial not above full");
      end
   endgenerate

   dacpc_xing_if x ();

   // Synchroniser stages for select and the three link toggles
   logic [3:0]       sync1_reg;
   logic [3:0]       sync2_reg;
   logic [3:0]       sync3_reg;
   logic [3:0]       sync_chg;
   logic             cs_low;
   logic             cs_rise;
   logic             cs_fall;
   logic             two_evt;
   logic             ten_evt;
   logic             trk_evt;

   // Power state and frame progress
   dacpc_pwr_t       state_reg;
   dacpc_pwr_t       state_next;
   logic             seen_two_reg;
   logic             seen_two_next;
   logic             seen_ten_reg;
   logic             seen_ten_next;
   logic             two_any;
   logic             ten_any;
   logic             abort_window;

   // Wake timing
   logic [CNT_W-1:0] settle_cnt_reg;
   logic [CNT_W-1:0] settle_cnt_next;
   logic [CNT_W-1:0] settle_load;
   logic [DWL_W-1:0] dwell_cnt_reg;
   logic [DWL_W-1:0] dwell_cnt_next;
   logic             dwell_ok;

   // Samples and registered outputs
   logic [11:0]      sample_first_reg;
   logic [11:0]      sample_second_reg;
   logic             track_mode_reg;
   logic             track_mode_next;
   logic             analog_on_reg;
   logic             reference_on_reg;
   logic             ready_reg;

   dacpc_link u_link (
      .serial_clk (serial_clk),
      .rstn       (rstn),
      .x          (x.link)
   );

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         sync1_reg <= `DACPC_SYNC_RST;
         sync2_reg <= `DACPC_SYNC_RST;
         sync3_reg <= `DACPC_SYNC_RST;
      end else begin
         sync1_reg <= {select_n, x.tog_track, x.tog_ten, x.tog_two};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   assign sync_chg = sync2_reg ^ sync3_reg;
   assign cs_low   = ~sync2_reg[3];
   assign cs_rise  = sync_chg[3] & sync2_reg[3];
   assign cs_fall  = sync_chg[3] & ~sync2_reg[3];
   assign two_evt  = sync_chg[0];
   assign ten_evt  = sync_chg[1];
   assign trk_evt  = sync_chg[2];

   // Edge counts seen in this frame; a new event wins over the frame clear
   assign seen_two_next = two_evt | (seen_two_reg & ~cs_fall);
   assign seen_ten_next = ten_evt | (seen_ten_reg & ~cs_fall);
   assign two_any       = seen_two_reg | two_evt;
   assign ten_any       = seen_ten_reg | ten_evt;
   assign abort_window  = cs_rise & two_any & ~ten_any;

   // Power state follows where select rose within the frame
   always_comb begin
      state_next = state_reg;
      if (ten_evt) begin
         state_next = DACPC_NORMAL;                                         // see [RQ4] see [RQ23]
      end else if (abort_window) begin                                      // see [RQ3]
         case (state_reg)
            DACPC_NORMAL:  state_next = DACPC_PARTIAL;                      // see [RQ1]
            DACPC_PARTIAL: state_next = DACPC_FULL;                         // see [RQ2]
            default:       state_next = DACPC_FULL;
         endcase
      end
   end

   // Short partial wake only after the reference settled in partial
   assign dwell_ok        = (dwell_cnt_reg == DWL_W'(PART_DWELL_CYC));
   assign dwell_cnt_next  = (state_reg != DACPC_PARTIAL) ? '0 :
                            dwell_ok ? dwell_cnt_reg : dwell_cnt_reg + DWL_W'(1);
   assign settle_load     = (state_reg == DACPC_FULL)   ? CNT_W'(WAKE_FULL_CYC) :
                            (state_reg == DACPC_NORMAL) ? '0 :
                            dwell_ok ? CNT_W'(WAKE_PART_CYC) : CNT_W'(WAKE_FULL_CYC);
   assign settle_cnt_next = cs_fall ? settle_load :
                            (settle_cnt_reg != '0) ? settle_cnt_reg - CNT_W'(1) : settle_cnt_reg;

   // Hold from select fall until the link reports the track edge or select rises
   assign track_mode_next = cs_fall ? 1'b0 :
                            (trk_evt | cs_rise) ? 1'b1 : track_mode_reg;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg    <= DACPC_NORMAL;
         seen_two_reg <= 1'b0;
         seen_ten_reg <= 1'b0;
      end else begin
         state_reg    <= state_next;
         seen_two_reg <= seen_two_next;                                     // see [RQ21]
         seen_ten_reg <= seen_ten_next;                                     // see [RQ20]
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         settle_cnt_reg <= '0;
         dwell_cnt_reg  <= '0;
      end else begin
         settle_cnt_reg <= settle_cnt_next;                                 // see [RQ5]
         dwell_cnt_reg  <= dwell_cnt_next;                                  // see [RQ6]
      end
   end

   // Words frozen while select is low, so the link reads them steady
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         sample_first_reg  <= 12'h000;
         sample_second_reg <= 12'h000;
      end else if (!cs_low) begin
         sample_first_reg  <= conv_first;                                   // see [RQ24]
         sample_second_reg <= conv_second;
      end
   end

   // Powering up begins at select fall and stops again at its rise unless the tenth edge restored normal mode
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         track_mode_reg   <= 1'b1;
         analog_on_reg    <= 1'b1;
         reference_on_reg <= 1'b1;
         ready_reg        <= 1'b1;
      end else begin
         track_mode_reg   <= track_mode_next;                               // see [RQ9] see [RQ10]
         analog_on_reg    <= (state_next == DACPC_NORMAL) | cs_low;
         reference_on_reg <= (state_next != DACPC_FULL) | cs_low;          // see [RQ22]
         ready_reg        <= (state_next == DACPC_NORMAL) & (settle_cnt_next == '0);
      end
   end

   assign x.cs_n        = select_n;
   assign x.word_first  = sample_first_reg;
   assign x.word_second = sample_second_reg;

   assign result_line_first     = x.dout_first;
   assign result_line_second    = x.dout_second;
   // Enable must follow select without waiting for a clock edge
   assign result_line_first_oe  = ~select_n & ~x.done;                     // see [RQ9] see [RQ14]
   assign result_line_second_oe = ~select_n & ~x.done;                     // see [RQ12]
   assign track_mode            = track_mode_reg;
   assign analog_on             = analog_on_reg;
   assign reference_on          = reference_on_reg;
   assign power_mode            = state_reg;
   assign conversion_ready      = ready_reg;

   AST_PARTIAL_ENTRY: assert property (@(posedge ref_clk) disable iff (!rstn)  // see [RQ1]
      (abort_window && !ten_evt && state_reg == DACPC_NORMAL)
         |=> state_reg == DACPC_PARTIAL && !analog_on_reg && reference_on_reg)
      else $error("abort in normal did not reach partial");

   AST_FULL_ENTRY: assert property (@(posedge ref_clk) disable iff (!rstn)     // see [RQ2]
      (abort_window && !ten_evt && state_reg == DACPC_PARTIAL)
         |=> state_reg == DACPC_FULL ##1 !reference_on_reg || cs_low)
      else $error("abort in partial did not reach full");

   AST_GLITCH_KEEP: assert property (@(posedge ref_clk) disable iff (!rstn)    // see [RQ21]
      (cs_rise && !two_any && !ten_evt) |=> $stable(state_reg))
      else $error("early select rise changed power state");

   AST_WAKE: assert property (@(posedge ref_clk) disable iff (!rstn)           // see [RQ4]
      ten_evt |=> state_reg == DACPC_NORMAL && analog_on_reg)
      else $error("tenth edge did not restore normal mode");

   AST_HOLD: assert property (@(posedge ref_clk) disable iff (!rstn)           // see [RQ9]
      cs_fall |=> !track_mode_reg && analog_on_reg)
      else $error("select fall did not enter hold");

   AST_KEEP_ON: assert property (@(posedge ref_clk) disable iff (!rstn)        // see [RQ20]
      (cs_rise && seen_ten_reg && state_reg == DACPC_NORMAL)
         |=> state_reg == DACPC_NORMAL [*2])
      else $error("late abort left normal mode");

   AST_FULL_WAKE_WAIT: assert property (@(posedge ref_clk) disable iff (!rstn) // see [RQ5]
      (cs_fall && state_reg == DACPC_FULL) |=> !ready_reg [*8])
      else $error("ready too soon after deep wake");

endmodule : dacpc_top

// ### logic/dacpc_xing_if.sv
// Signals between the reference-clock core and the serial-clock link logic.
// Assumes the core instantiates it once and hands the link modport on; the core owns words, the link owns toggles.
`timescale 1ns/1ps
interface dacpc_xing_if;
   logic        cs_n;
   logic [11:0] word_first;
   logic [11:0] word_second;
   logic        tog_two;
   logic        tog_ten;
   logic        tog_track;
   logic        dout_first;
   logic        dout_second;
   logic        done;

   modport core (
      output cs_n,
      output word_first,
      output word_second,
      input  tog_two,
      input  tog_ten,
      input  tog_track,
      input  dout_first,
      input  dout_second,
      input  done
   );

   modport link (
      input  cs_n,
      input  word_first,
      input  word_second,
      output tog_two,
      output tog_ten,
      output tog_track,
      output dout_first,
      output dout_second,
      output done
   );
endinterface : dacpc_xing_if

// ### tb/dacpc_host_model.sv
// Host serial master: drives select and the serial clock, samples both result lines.
// Assumes the bench calls frame() between frames; serial clock idles high and still.
`timescale 1ns/1ps
module dacpc_host_model (
   output logic      select_n,
   output logic      serial_clk,
   input  wire logic line_first,
   input  wire logic oe_first,
   input  wire logic line_second,
   input  wire logic oe_second,
   input  wire logic track_mode
);
   logic       cap_first  [0:32];
   logic       cap_second [0:32];
   logic [1:0] cap_oe     [0:32];
   logic       cap_track  [0:32];
   logic [1:0] oe_after_rise;

   initial begin
      select_n      = 1'b1;
      serial_clk    = 1'b1;
      oe_after_rise = 2'h0;
   end

   task automatic grab(input int k);
      cap_first[k]  = line_first;
      cap_second[k] = line_second;
      cap_oe[k]     = {oe_first, oe_second};
      cap_track[k]  = track_mode;
   endtask : grab

   // Frame of n counted falls; early adds a fall coincident with select
   task automatic frame(input int n, input bit early);
      int k;
      // Early fall lands just ahead of select, the coincident case
      if (early) begin
         serial_clk = 1'b0;
         #0.1;
      end
      select_n = 1'b0;
      #30 serial_clk = 1'b1;
      #10 grab(0);
      #40;
      for (k = 1; k <= n; k++) begin
         serial_clk = 1'b0;
         #16 serial_clk = 1'b1;
         grab(k);
         #16;
      end
      select_n = 1'b1;
      #1 oe_after_rise = {oe_first, oe_second};
      #40;
   endtask : frame
endmodule : dacpc_host_model

// ### tb/testbench.sv
// Self-checking bench for the dual converter read-out and power control block.
// Assumes the host model paces all frames; words change only between frames.
`timescale 1ns/1ps
module testbench;
   import dacpc_pkg::*;
   localparam int WAKE_FULL  = 50;
   localparam int WAKE_PART  = 4;
   localparam int PART_DWELL = 20;

   logic        ref_clk;
   logic        rstn;
   logic        select_n;
   logic        serial_clk;
   logic [11:0] conv_first;
   logic [11:0] conv_second;
   logic        line_f;
   logic        oe_f;
   logic        line_s;
   logic        oe_s;
   logic        track_mode;
   logic        analog_on;
   logic        reference_on;
   logic [1:0]  power_mode;
   logic        conversion_ready;
   int          mismatches;
   int          cmp_count;

   dacpc_top #(.WAKE_FULL_CYC(WAKE_FULL), .WAKE_PART_CYC(WAKE_PART),
               .PART_DWELL_CYC(PART_DWELL)) dut_u (
      .ref_clk(ref_clk), .rstn(rstn), .serial_clk(serial_clk), .select_n(select_n),
      .conv_first(conv_first), .conv_second(conv_second),
      .result_line_first(line_f), .result_line_first_oe(oe_f),
      .result_line_second(line_s), .result_line_second_oe(oe_s),
      .track_mode(track_mode), .analog_on(analog_on), .reference_on(reference_on),
      .power_mode(power_mode), .conversion_ready(conversion_ready)
   );

   dacpc_host_model host_u (
      .select_n(select_n), .serial_clk(serial_clk), .line_first(line_f), .oe_first(oe_f),
      .line_second(line_s), .oe_second(oe_s), .track_mode(track_mode)
   );

   always #12.5 ref_clk = ~ref_clk;

   task automatic check1(input string name, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %b, seen %b", name, exp, got);
      end
   endtask : check1

   task automatic check2(input string name, input logic [1:0] exp, input logic [1:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %b, seen %b", name, exp, got);
      end
   endtask : check2

   task automatic report_and_stop();
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : report_and_stop

   // Slot k of the 16-slot word layout
   function automatic logic exp_bit(input logic [11:0] w, input int k);
      int s;
      s = k % 16;
      if (s >= 2 && s <= 13) return w[13 - s];
      return 1'b0;
   endfunction : exp_bit

   task automatic set_words(input logic [11:0] a, input logic [11:0] b);
      @(negedge ref_clk);
      conv_first  = a;
      conv_second = b;
      repeat (4) @(negedge ref_clk);
   endtask : set_words

   task automatic settle();
      repeat (10) @(negedge ref_clk);
   endtask : settle

   task automatic t_read(input logic [11:0] a, input logic [11:0] b, input int n,
                         input bit early);
      int          k;
      logic [11:0] wf;
      logic [11:0] ws;
      set_words(a, b);
      host_u.frame(n, early);
      for (k = 0; k <= n && k < 32; k++) begin
         wf = (k < 16) ? a : b;
         ws = (k < 16) ? b : a;
         check1("line_first", exp_bit(wf, k), host_u.cap_first[k]);
         check1("line_second", exp_bit(ws, k), host_u.cap_second[k]);
         check2("oe_pair", 2'h3, host_u.cap_oe[k]);
      end
      if (n == 32) begin
         check2("oe_pair_end", 2'h0, host_u.cap_oe[32]);
         check1("track_held", 1'b0, host_u.cap_track[12]);
         check1("track_back", 1'b1, host_u.cap_track[20]);
      end
      check2("oe_after_rise", 2'h0, host_u.oe_after_rise);
      settle();
      check2("power_mode", DACPC_NORMAL, power_mode);
   endtask : t_read

   task automatic t_abort_late();
      set_words(12'h0f1, 12'h9e2);
      host_u.frame(12, 1'b0);
      check2("oe_after_rise", 2'h0, host_u.oe_after_rise);
      settle();
      check2("power_mode", DACPC_NORMAL, power_mode);
      check1("analog_on", 1'b1, analog_on);
   endtask : t_abort_late

   task automatic t_power_cycle();
      host_u.frame(5, 1'b0);
      settle();
      check2("power_mode", DACPC_PARTIAL, power_mode);
      check1("analog_on", 1'b0, analog_on);
      check1("reference_on", 1'b1, reference_on);
      host_u.frame(1, 1'b0);
      settle();
      check2("power_mode", DACPC_PARTIAL, power_mode);
      host_u.frame(5, 1'b0);
      settle();
      check2("power_mode", DACPC_FULL, power_mode);
      check1("reference_on", 1'b0, reference_on);
      check1("analog_on", 1'b0, analog_on);
      host_u.frame(16, 1'b0);
      settle();
      check2("power_mode", DACPC_NORMAL, power_mode);
      check1("analog_on", 1'b1, analog_on);
      check1("conversion_ready", 1'b0, conversion_ready);
      repeat (WAKE_FULL + 10) @(negedge ref_clk);
      check1("conversion_ready", 1'b1, conversion_ready);
   endtask : t_power_cycle

   // Wake from partial: short wait after a long dwell, full wait after a short one
   task automatic t_part_wake();
      host_u.frame(5, 1'b0);
      repeat (PART_DWELL + 20) @(negedge ref_clk);
      host_u.frame(16, 1'b0);
      settle();
      check1("ready_long_dwell", 1'b1, conversion_ready);
      host_u.frame(5, 1'b0);
      host_u.frame(16, 1'b0);
      settle();
      check1("ready_short_dwell", 1'b0, conversion_ready);
      repeat (WAKE_FULL + 10) @(negedge ref_clk);
      check1("ready_after_wait", 1'b1, conversion_ready);
      check2("power_mode", DACPC_NORMAL, power_mode);
   endtask : t_part_wake

   initial begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      report_and_stop();
   end

   initial begin
      ref_clk     = 1'b0;
      rstn        = 1'b0;
      conv_first  = 12'h000;
      conv_second = 12'h000;
      mismatches  = 0;
      cmp_count   = 0;
      repeat (4) @(negedge ref_clk);
      check2("power_mode_rst", DACPC_NORMAL, power_mode);
      check1("track_rst", 1'b1, track_mode);
      check1("ready_rst", 1'b1, conversion_ready);
      rstn = 1'b1;
      repeat (4) @(negedge ref_clk);
      t_read(12'hac5, 12'h3e1, 32, 1'b0);
      t_read(12'h5a3, 12'hc3c, 16, 1'b1);
      t_abort_late();
      t_power_cycle();
      t_part_wake();
      t_read(12'h801, 12'h7fe, 14, 1'b0);
      report_and_stop();
   end
endmodule : testbench
